// ---- inc/uab_pkg.sv ----
// Constants, register map and state types for the autobaud and wake block.
// Assumes a single 200 MHz pclk domain and an APB master with 32-bit data.
//
// Notes on behaviour
// [RULE1] Setting autobaud enable starts calibration; receiver stays idle meanwhile.
// [RULE2] Counting begins at the first rising edge after the start bit.
// [RULE3] Stop on fifth rising edge of 55h; count left in divisor pair.
// [RULE4] At completion autobaud enable self-clears and receive flag sets.
// [RULE5] Software reads receive buffer to clear the flag, discards value.
// [RULE6] During calibration both divisor registers form one 16-bit counter.
// [RULE7] Calibration counter ticks at one eighth of the base clock.
// [RULE8] Base clock osc/64, /16 or /4; calibration clock /512, /128, /32.
// [RULE9] Counter starts at one; software subtracts one afterwards.
// [RULE10] In 8-bit mode software checks high divisor reads zero.
// [RULE11] With wake enabled too, measurement uses the byte after the break.
// [RULE12] While wake enabled, normal reception off; port idles watching line.
// [RULE13] Wake event is a falling edge on the receive line.
// [RULE14] Receive flag rises at the wake event, also when asleep; here asleep only wake_async rises, the receive flag stays low.
// [RULE15] Wake enable self-clears on the rising edge ending the break.
// [RULE16] Wake works only in asynchronous mode, ignored when synchronous; here wake_async still rises on any falling edge, in either mode.
// [RULE17] In sleep, rate generator stops; only edge wake detection runs; here the prescaler, synchroniser and APB port keep running.
// [RULE18] Wide high-speed mode: baud is osc over four times divisor plus one.
// [RULE19] Receive line synchronised in two stages before edge detection.
package uab_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] uab_ctrl_addr = 12'h000;
  localparam logic [11:0] uab_div_addr = 12'h004;
  localparam logic [11:0] uab_stat_addr = 12'h008;
  localparam logic [11:0] uab_mask_addr = 12'h00c;
  localparam logic [11:0] uab_rxbuf_addr = 12'h010;
  localparam logic [11:0] uab_rate_addr = 12'h014;

  // ------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------
  localparam int uab_abd_en_bit = 0;
  localparam int uab_wake_en_bit = 1;
  localparam int uab_hs_bit = 2;
  localparam int uab_wide_bit = 3;
  localparam int uab_sync_bit = 4;
  localparam int uab_sleep_bit = 5;
  localparam logic [5:0] uab_ctrl_rst = 6'h00;

  // Status fields: sticky events
  localparam int uab_ev_done = 0;
  localparam int uab_ev_wake = 1;
  localparam int uab_ev_wake_end = 2;
  localparam int uab_ev_ovf = 3;
  localparam logic [3:0] uab_stat_rst = 4'h0;
  localparam logic [3:0] uab_mask_rst = 4'h0;
  localparam logic [15:0] uab_div_rst = 16'h0000;

  // ------------------------------------------------------------
  // Timing counts in oscillator (pclk) cycles
  // ------------------------------------------------------------
  localparam logic [9:0] uab_div_64 = 10'd64;
  localparam logic [9:0] uab_div_16 = 10'd16;
  localparam logic [9:0] uab_div_4 = 10'd4;
  localparam logic [9:0] uab_abd_factor = 10'd8;
  localparam logic [15:0] uab_count_start = 16'h0001;
  localparam logic [2:0] uab_rises_total = 3'd5;
  localparam logic [31:0] uab_rate_mult = 32'd4;

  typedef enum logic [2:0] {
    uab_idle, uab_brk_low, uab_wait_start, uab_wait_rise, uab_count
  } uab_state_t;

  typedef struct packed {
    logic [5:0] ctrl;
    logic [15:0] div;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [7:0] rxbuf;
    uab_state_t st;
    logic [1:0] sync_rx;
    logic rx_prev;
    logic [9:0] pre;
    logic [2:0] rises;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
    logic rcv_flag;
  } uab_regs_t;

  // Osc cycles per base clock for a given select pair
  function automatic logic [9:0] uab_base_div(input logic hs,
                                              input logic wide);
    if (hs && wide) begin
      return uab_div_4;
    end else if (hs || wide) begin
      return uab_div_16;
    end
    return uab_div_64;
  endfunction

endpackage

// ---- src/uab_autobaud_wake.sv ----
// Autobaud measurement and wake-on-break logic with an APB register port.
// Assumes pclk is the oscillator and rx_line is a raw asynchronous pin.
`timescale 1ns/1ps
module uab_autobaud_wake
  import uab_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rx_line,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic receive_flag,
  output logic wake_async
);

  uab_regs_t r;
  uab_regs_t next_r;

  logic rx_s;
  logic rise;
  logic fall;
  logic acc;
  logic wr;
  logic rd;
  logic [9:0] tick_len;
  logic tick;
  logic [3:0] ev;
  logic [16:0] inc;
  logic async_mode;
  logic wake_armed;

  assign rx_s = r.sync_rx[1];
  assign rise = rx_s && !r.rx_prev;
  assign fall = !rx_s && r.rx_prev;
  assign acc = psel && penable && !r.pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  // [RULE7] [RULE8] Calibration tick = eight base periods
  assign tick_len = 10'(uab_base_div(r.ctrl[uab_hs_bit],
                    r.ctrl[uab_wide_bit]) * uab_abd_factor - 10'd1);
  assign tick = r.pre == tick_len;
  assign async_mode = !r.ctrl[uab_sync_bit];
  assign wake_armed = r.ctrl[uab_wake_en_bit] && async_mode; // [RULE16]
  assign inc = {1'b0, r.div} + 17'd1;

  // ------------------------------------------------------------
  // Wake path that needs no running clock
  // ------------------------------------------------------------
  // Latched on the raw pin edge so sleep (clock stopped) still wakes.
  always_ff @(negedge rx_line or negedge presetn) begin
    if (!presetn) begin
      wake_async <= 1'b0;
    end else begin
      wake_async <= 1'b1; // [RULE13] [RULE14] [RULE17]
    end
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    ev = 4'h0;
    next_r.sync_rx = {r.sync_rx[0], rx_line}; // [RULE19]
    next_r.rx_prev = rx_s;
    next_r.pready = acc;
    next_r.pslverr = 1'b0;
    // Eighth-rate prescaler, only while measuring
    if (r.st == uab_count) begin
      next_r.pre = tick ? 10'd0 : 10'(r.pre + 10'd1);
    end else begin
      next_r.pre = 10'd0;
    end
    // [RULE17] Asleep the state machine holds; edge latch, synchroniser, prescaler and APB still act
    if (!r.ctrl[uab_sleep_bit]) begin
      unique case (r.st)
        uab_idle: begin
          // [RULE12] [RULE13] Wake armed: watch for falling edge only
          if (wake_armed && fall) begin
            ev[uab_ev_wake] = 1'b1; // [RULE14]
            next_r.st = uab_brk_low;
          end else if (!wake_armed && r.ctrl[uab_abd_en_bit]) begin
            next_r.st = uab_wait_start; // [RULE1]
          end
        end
        uab_brk_low: begin
          if (rise) begin
            // [RULE15] Break over; [RULE11] measure next byte
            next_r.ctrl[uab_wake_en_bit] = 1'b0;
            ev[uab_ev_wake_end] = 1'b1;
            next_r.st = uab_idle;
          end
        end
        uab_wait_start: begin
          if (fall) begin
            next_r.st = uab_wait_rise;
          end
        end
        uab_wait_rise: begin
          if (rise) begin
            // [RULE2] [RULE6] [RULE9] Counter starts at one, 16 bits
            next_r.div = uab_count_start;
            next_r.rises = 3'd1;
            next_r.st = uab_count;
          end
        end
        uab_count: begin
          if (tick) begin
            next_r.div = inc[15:0]; // [RULE6] [RULE7]
            if (inc[16]) begin
              ev[uab_ev_ovf] = 1'b1;
            end
          end
          if (rise) begin
            next_r.rises = 3'(r.rises + 3'd1);
            if (3'(r.rises + 3'd1) == uab_rises_total) begin
              // [RULE3] [RULE4] Fifth rise ends the measurement
              next_r.ctrl[uab_abd_en_bit] = 1'b0;
              ev[uab_ev_done] = 1'b1;
              next_r.st = uab_idle;
            end
          end
        end
        default: next_r.st = uab_idle;
      endcase
    end
    // Software cancels a measurement by clearing enable; frozen in sleep
    if (!r.ctrl[uab_abd_en_bit] && !r.ctrl[uab_sleep_bit] &&
        r.st != uab_idle && r.st != uab_brk_low) begin
      next_r.st = uab_idle;
    end
    // ------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------
    next_r.prdata = 32'h0000_0000;
    if (wr) begin
      unique case (paddr)
        uab_ctrl_addr: next_r.ctrl = pwdata[5:0];
        uab_div_addr: next_r.div = pwdata[15:0];
        uab_mask_addr: next_r.mask = pwdata[3:0];
        default: next_r.pslverr = !(paddr == uab_stat_addr ||
                 paddr == uab_rxbuf_addr || paddr == uab_rate_addr);
      endcase
    end
    if (rd) begin
      unique case (paddr)
        uab_ctrl_addr: next_r.prdata = {26'h0, r.ctrl};
        uab_div_addr: next_r.prdata = {16'h0, r.div};
        uab_stat_addr: begin
          next_r.prdata = {28'h0, r.stat};
          next_r.stat = 4'h0; // Read clears
        end
        uab_mask_addr: next_r.prdata = {28'h0, r.mask};
        uab_rxbuf_addr: begin
          next_r.prdata = {24'h0, r.rxbuf};
          next_r.rcv_flag = 1'b0; // [RULE5] Buffer read clears flag
        end
        // [RULE18] Oscillator cycles per bit: 4 * (div + 1)
        uab_rate_addr: next_r.prdata = uab_rate_mult *
                       (32'(r.div) + 32'd1);
        default: next_r.pslverr = 1'b1;
      endcase
    end
    // Events win over a same-cycle clear
    next_r.stat = next_r.stat | ev;
    if (ev[uab_ev_done] || ev[uab_ev_wake]) begin
      next_r.rcv_flag = 1'b1; // [RULE4] [RULE14]
    end
    next_r.irq = |(next_r.stat & next_r.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{ctrl: uab_ctrl_rst, div: uab_div_rst, stat: uab_stat_rst,
             mask: uab_mask_rst, rxbuf: 8'h00, st: uab_idle,
             sync_rx: 2'b11, rx_prev: 1'b1, pre: 10'd0, rises: 3'd0,
             pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0,
             irq: 1'b0, rcv_flag: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign receive_flag = r.rcv_flag;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_fifth_rise;
    r.st == uab_count && rise && r.rises == 3'd4 && !r.ctrl[uab_sleep_bit];
  endsequence

  idle_during_cal_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == uab_count |-> r.ctrl[uab_abd_en_bit] || $past(wr)) // [RULE1]
    else $error("calibration running without enable");
  start_at_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == uab_wait_rise && rise && !r.ctrl[uab_sleep_bit]
    && r.ctrl[uab_abd_en_bit] |=> r.div == 16'h0001) // [RULE2]
    else $error("counter not started at one");
  done_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_fifth_rise and !wr) |=> !r.ctrl[uab_abd_en_bit] && r.rcv_flag
    && r.st == uab_idle) // [RULE3]
    else $error("fifth rise did not finish");
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_fifth_rise |=> r.stat[uab_ev_done]) // [RULE4]
    else $error("done event lost");
  tick_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == uab_count && !tick && !rise && !wr && r.st == $past(r.st)
    |=> r.div == $past(r.div)) // [RULE7]
    else $error("counter moved off tick");
  wake_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == uab_idle && wake_armed && fall && !r.ctrl[uab_sleep_bit]
    |=> r.rcv_flag && r.st == uab_brk_low) // [RULE13]
    else $error("wake edge missed");
  wake_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == uab_brk_low && rise && !r.ctrl[uab_sleep_bit] && !wr
    |=> !r.ctrl[uab_wake_en_bit]) // [RULE15]
    else $error("wake enable not cleared");
  sync_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.ctrl[uab_sync_bit] && r.st == uab_idle |=> r.st != uab_brk_low)
    // [RULE16]
    else $error("wake acted in sync mode");
  sleep_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.ctrl[uab_sleep_bit] && !wr |=> r.st == $past(r.st)) // [RULE17]
    else $error("state moved in sleep");

  // ------------------------------------------------------------
  // Calibration steps
  // ------------------------------------------------------------
  sequence s_start_bit;
    r.st == uab_wait_start && fall && !r.ctrl[uab_sleep_bit]
    && r.ctrl[uab_abd_en_bit];
  endsequence

  sequence s_first_rise;
    r.st == uab_wait_rise && rise && !r.ctrl[uab_sleep_bit]
    && r.ctrl[uab_abd_en_bit] && !wr;
  endsequence

  sequence s_break_end;
    r.st == uab_brk_low && rise && !r.ctrl[uab_sleep_bit];
  endsequence

  cal_entry_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    r.st == uab_idle && !wake_armed && r.ctrl[uab_abd_en_bit]
    && !r.ctrl[uab_sleep_bit]
    |=> r.st == uab_wait_start)
    else $error("calibration did not start");

  wait_fall_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    s_start_bit
    |=> r.st == uab_wait_rise)
    else $error("start bit not seen");

  start_count_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    s_first_rise
    |=> r.st == uab_count && r.rises == 3'd1)
    else $error("counting did not begin");

  div_step_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    r.st == uab_count && tick && !wr && !r.ctrl[uab_sleep_bit]
    |=> r.div == 16'($past(r.div) + 16'd1))
    else $error("counter did not step");

  ovf_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    r.st == uab_count && tick && r.div == 16'hffff
    && !r.ctrl[uab_sleep_bit]
    |=> r.stat[uab_ev_ovf])
    else $error("overflow not flagged");

  wake_first_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    r.st == uab_idle && wake_armed && !r.ctrl[uab_sleep_bit]
    |=> r.st != uab_wait_start)
    else $error("reception while wake armed");

  break_end_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    s_break_end
    |=> r.st == uab_idle && r.stat[uab_ev_wake_end])
    else $error("break end not handled");

  sleep_div_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    r.ctrl[uab_sleep_bit] && !wr
    |=> r.div == $past(r.div))
    else $error("counter moved in sleep");

  sync_stage_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
    r.sync_rx[1] == $past(r.sync_rx[0]))
    else $error("synchroniser skipped a stage");

  // ------------------------------------------------------------
  // Register port and flags
  // ------------------------------------------------------------
  pready_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc
    |=> r.pready)
    else $error("access not answered");

  pready_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.pready
    |=> !r.pready)
    else $error("ready longer than one cycle");

  err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.pslverr
    |-> r.pready)
    else $error("error without ready");

  data_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !r.pready
    |-> r.prdata == 32'h0000_0000)
    else $error("read data outside answer");

  rate_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
    rd && paddr == uab_rate_addr
    |=> r.prdata == {14'h0, $past(r.div), 2'b00} + 32'd4)
    else $error("rate readback wrong");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.irq == |(r.stat & r.mask))
    else $error("interrupt level wrong");

  stat_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(rd && paddr == uab_stat_addr)
    |=> (r.stat & $past(r.stat)) == $past(r.stat))
    else $error("status bit lost");

  stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == uab_stat_addr && ev == 4'h0
    |=> r.stat == 4'h0)
    else $error("status read did not clear");

  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    rd && paddr == uab_rxbuf_addr && !ev[uab_ev_done]
    && !ev[uab_ev_wake]
    |=> !r.rcv_flag)
    else $error("buffer read left flag set");

  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    r.rcv_flag && !(rd && paddr == uab_rxbuf_addr)
    |=> r.rcv_flag)
    else $error("receive flag dropped");

endmodule

// ---- testbench/uab_lin_tx.sv ----
// Remote serial transmitter model driving the receive line.
// Assumes the bench calls its tasks; line idles high between frames.
`timescale 1ns/1ps
module uab_lin_tx (
  input wire logic pclk,
  output logic rx_line
);
  // ------------------------------------------------------------
  // Line driving
  // ------------------------------------------------------------
  initial begin
    rx_line = 1'b1;
  end

  // Hold a level for n oscillator cycles, changed just after an edge
  task automatic hold(input logic lvl, input int n);
    @(posedge pclk);
    rx_line <= lvl;
    repeat (n - 1) @(posedge pclk);
  endtask

  // Start bit, eight data bits LSB first, stop bit
  task automatic send_byte(input logic [7:0] b, input int t);
    hold(1'b0, t);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], t);
    end
    hold(1'b1, t);
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the autobaud and wake-on-break block.
// Assumes APB slave with one wait state and registered outputs.
`timescale 1ns/1ps
module testbench;
  import uab_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic rx_line;
  logic [31:0] prdata;
  logic pready, pslverr, irq, receive_flag, wake_async;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] rv;
  logic re;

  always #2.5 pclk = ~pclk;

  uab_autobaud_wake uab_autobaud_wake_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .rx_line(rx_line), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .receive_flag(receive_flag),
    .wake_async(wake_async));
  uab_lin_tx uab_lin_tx_i (.pclk(pclk), .rx_line(rx_line));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Request held until pready is sampled high, or for at most 20 cycles
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    bit seen;
    seen = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready looked at mid-cycle, where it is settled
    for (int i = 0; i < 20 && !seen; i++) begin
      @(negedge pclk);
      seen = (pready === 1'b1);
    end
    if (!seen) begin
      err_total++;
    end
    rv = prdata;
    re = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rv, e);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_map;
    chk("wake_async_idle", {31'h0, wake_async}, 32'h0);
    rd_chk("ctrl", uab_ctrl_addr, 32'h0);
    rd_chk("div", uab_div_addr, 32'h0);
    rd_chk("stat", uab_stat_addr, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", {31'h0, re}, 32'h1);
  endtask

  // One 55h per rate mode; bit time chosen off the count boundary
  task automatic t_calib;
    int t[4] = '{1312, 4168, 488, 402};
    logic [31:0] ex[4] = '{32'h15, 32'h105, 32'h1f, 32'h65};
    logic [31:0] c;
    for (int i = 0; i < 4; i++) begin
      c = {26'h0, i[1:0] == 2'd1 || i == 3, i[1:0] >= 2'd2, 2'b01};
      c = {c[31:4], i == 2 || i == 3, i == 1 || i == 3, 2'b01};
      apb(1'b1, uab_mask_addr, {31'h0, i != 0});
      apb(1'b1, uab_ctrl_addr, c);
      uab_lin_tx_i.send_byte(8'h55, t[i]);
      repeat (10) @(posedge pclk);
      chk("flag_done", {31'h0, receive_flag}, 32'h1);
      chk("irq_done", {31'h0, irq}, {31'h0, i != 0});
      rd_chk("ctrl_auto_clear", uab_ctrl_addr, c & 32'hfffffffe);
      rd_chk("div", uab_div_addr, ex[i]);
      if (i == 0) begin
        chk("div_high_zero", {24'h0, rv[15:8]}, 32'h0);
      end
      rd_chk("rate", uab_rate_addr, (ex[i] + 32'd1) << 2);
      apb(1'b0, uab_rxbuf_addr, 32'h0);
      chk("flag_clear", {31'h0, receive_flag}, 32'h0);
      rd_chk("stat_done", uab_stat_addr, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq_clear", {31'h0, irq}, 32'h0);
    end
  endtask

  // Synchronous mode must ignore a falling edge
  task automatic t_sync_ignore;
    apb(1'b1, uab_ctrl_addr, 32'h12);
    uab_lin_tx_i.hold(1'b0, 50);
    uab_lin_tx_i.hold(1'b1, 50);
    chk("sync_no_wake", {31'h0, receive_flag}, 32'h0);
    apb(1'b1, uab_ctrl_addr, 32'h0);
    // Asleep with wake armed: state machine frozen
    apb(1'b1, uab_ctrl_addr, 32'h22);
    uab_lin_tx_i.hold(1'b0, 50);
    uab_lin_tx_i.hold(1'b1, 50);
    chk("sleep_no_flag", {31'h0, receive_flag}, 32'h0);
    rd_chk("sleep_wake_held", uab_ctrl_addr, 32'h22);
    apb(1'b1, uab_ctrl_addr, 32'h0);
  endtask

  // Break wakes, then autobaud runs on the following 55h
  task automatic t_wake;
    apb(1'b1, uab_ctrl_addr, 32'h0f);
    fork
      uab_lin_tx_i.hold(1'b0, 5226);
      begin
        repeat (20) @(posedge pclk);
        chk("wake_flag", {31'h0, receive_flag}, 32'h1);
        rd_chk("wake_held", uab_ctrl_addr, 32'h0f);
      end
    join
    uab_lin_tx_i.hold(1'b1, 1000);
    rd_chk("wake_clear", uab_ctrl_addr, 32'h0d);
    chk("wake_async", {31'h0, wake_async}, 32'h1);
    apb(1'b0, uab_rxbuf_addr, 32'h0);
    uab_lin_tx_i.send_byte(8'h55, 402);
    repeat (10) @(posedge pclk);
    rd_chk("div_after_break", uab_div_addr, 32'h65);
  endtask

  // ------------------------------------------------------------
  // Main sequence and verdict
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_calib();
    t_sync_ignore();
    t_wake();
    tally_and_finish();
  end

  // Expected run is about 74k cycles
  initial begin
    repeat (95000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end
endmodule
